// >>> rtl/sdc_map.svh
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
// serial addresses of the two control registers
`define SDC_ADDR_PRI      5'h00
`define SDC_ADDR_SEC      5'h01
// data lengths in bits, and the index of the last instruction bit
`define SDC_PRI_BITS      6'd32
`define SDC_SEC_BITS      6'd40
`define SDC_INSTR_BITS    3'd7
// instruction byte fields
`define SDC_INSTR_RD      7
`define SDC_INSTR_ADDR_HI 4
// primary_control fields
`define SDC_P_LOCK_ERR    24
`define SDC_P_NO_DWELL    16
`define SDC_P_LSB_FIRST   15
`define SDC_P_THREE_WIRE  14
`define SDC_P_DIG_PD      7
`define SDC_P_PFD_IN_PD   6
`define SDC_P_SYNC_GATE   4
`define SDC_P_AUTO_SYNC   3
`define SDC_P_SW_SYNC     2
`define SDC_P_HW_SYNC     1
`define SDC_P_HS_SYNC     0
`define SDC_P_WR_MASK     32'h00FF_C0FB
`define SDC_P_RESET       32'h0000_0000
// secondary_control fields
`define SDC_S_DAC_PD      39
`define SDC_S_BG_PD       33
`define SDC_S_INT_RSET    32
`define SDC_S_RISE_HI     31
`define SDC_S_RISE_LO     29
`define SDC_S_FALL_HI     28
`define SDC_S_FALL_LO     26
`define SDC_S_LOCK_DET_EN 25
`define SDC_S_WR_MASK     40'h83_FFFF_FFFF
`define SDC_S_RESET       40'h00_0078_0000
// timing
`define SDC_CLK_MHZ       50
`define SDC_BG_SETTLE_US  10000
`define SDC_BG_SETTLE_CYC (`SDC_BG_SETTLE_US * `SDC_CLK_MHZ)
`endif

// >>> rtl/sdc_pkg.sv
package sdc_pkg;
    // serial port states, gray along idle->instr->data->wait
    typedef enum logic [1:0] {
        SDC_IDLE  = 2'b00,
        SDC_INSTR = 2'b01,
        SDC_DATA  = 2'b11,
        SDC_WAIT  = 2'b10
    } sdc_port_st_t;
endpackage

// >>> rtl/sdc_sync_div.sv
`timescale 1ns/1ps
`default_nettype none
// sync clock: system clock divided by four, with advance and align
module sdc_sync_div
    import sdc_pkg::*;
(
    input  wire logic       clk,       // system clock
    input  wire logic       rst_n,     // async reset, low
    input  wire logic       run,       // clock enable, low freezes
    input  wire logic       advance,   // one-cycle pulse, edges earlier
    input  wire logic       align,     // one-cycle pulse, load phase
    input  wire logic [1:0] align_val, // phase loaded on align
    output logic            sync_clk   // divided clock level
);
    logic [1:0] phase_q;               // divider phase
    logic [1:0] phase_d;
    logic       sync_q;                // registered output
    logic       sync_d;

    // next phase: align wins, advance skips one step
    always_comb begin
        phase_d = phase_q;
        if (run) begin
            if (align) begin
                phase_d = align_val;
            end else if (advance) begin
                phase_d = phase_q + 2'd2;
            end else begin
                phase_d = phase_q + 2'd1;
            end
        end
        sync_d = ~phase_d[1];
    end

    // phase and output registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 2'd0;
            sync_q  <= 1'b1;
        end else begin
            phase_q <= phase_d;
            sync_q  <= sync_d;
        end
    end

    assign sync_clk = sync_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_div_advance: assert property (run && advance && !align |=> phase_q == $past(phase_q) + 2'd2)
        else $error("advance did not skip a phase step");
    a_div_freeze: assert property (!run |=> $stable(phase_q))
        else $error("divider moved while frozen");
    a_div_align: assert property (run && align |=> phase_q == $past(align_val))
        else $error("alignment did not load the divider phase");
endmodule
`default_nettype wire

// >>> rtl/sdc_top.sv
// Contract
// - no-dwell clear: hold upper word at sweep end
// - no-dwell set: return to start, wait profile pulse
// - bit-order bit picks MSB or LSB first
// - wire-mode picks two-wire or three-wire readback
// - digital power-down stops all but serial port; lock error flag and band-gap settle count keep running
// - detector power-down disables detector input buffers
// - gating bit floats the sync output pin
// - auto sync aligns sync clock to pin
// - software sync advances sync clock, self-clears
// - hardware sync: pin rising edge advances clock
// - lock loss in sync-input mode sets error
// - shared pin outputs lock when lock-detect enabled and not sync input
// - high-speed sync bit enables extra alignment
// - converter power-down floats converter output
// - band-gap power-down, about 10 ms settling
// - resistor select uses internal driver resistor
// - rising surge bits add cumulative current
// - falling surge bits add cumulative current
// - lock-detect enable drives lock on pin
// - lock error sticky, cleared by primary readback
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"
module sdc_top
    import sdc_pkg::*;
#(
    parameter int unsigned BG_SETTLE_CYC = `SDC_BG_SETTLE_CYC // band-gap settle cycles
)(
    input  wire logic       CLK_SYS,             // system clock, 50 MHz
    input  wire logic       RST_N,               // async reset, low
    input  wire logic       SCLK,                // serial clock, sampled
    input  wire logic       CS_N,                // serial select, low
    input  wire logic       SDIO_I,              // serial data pin in
    output logic            SDIO_O,              // serial data pin out
    output logic            SDIO_OE,             // serial data pin drive
    output logic            SDO_O,               // serial output pin
    output logic            SDO_OE,              // serial output drive
    input  wire logic       LOCK_SYNC_I,         // shared pin in
    output logic            LOCK_SYNC_O,         // shared pin out
    output logic            LOCK_SYNC_OE,        // shared pin drive
    input  wire logic       PLL_LOCKED,          // loop lock status
    output logic            SYNC_OUT,            // sync clock pin
    output logic            SYNC_OUT_OE,         // sync pin drive
    input  wire logic       SWEEP_AT_END,        // sweep hit upper word
    input  wire logic       PROFILE_SELECT_BIT0, // profile select input
    output logic            SWEEP_HOLD_END,      // hold end word
    output logic            SWEEP_RETURN_START,  // output start word
    output logic            DIG_CLK_EN,          // digital clock enable
    output logic            PFD_IN_EN,           // detector buffers on
    output logic            HS_SYNC_EN,          // high-speed sync mode
    output logic            DAC_PD,              // converter power-down
    output logic            DAC_OUT_OE,          // converter output on
    output logic            BANDGAP_PD,          // reference power-down
    output logic            BANDGAP_SETTLED,     // reference settled
    output logic            DRV_INT_RSET,        // internal resistor
    output logic            DRV_EXT_RSET_EN,     // resistor pin in use
    output logic [2:0]      RISE_SURGE_EN,       // rising surge legs
    output logic [2:0]      FALL_SURGE_EN        // falling surge legs
);
    sdc_port_st_t st_q, st_d;      // serial port state
    logic [5:0]  cnt_q, cnt_d;     // bit counter
    logic [7:0]  instr_q, instr_d; // instruction byte
    logic [39:0] sh_q, sh_d;       // data shift register
    logic        out_q, out_d;     // serial output bit
    logic        sclk_q;           // previous serial clock
    logic [31:0] pri_q, pri_d;     // primary_control
    logic [39:0] sec_q, sec_d;     // secondary_control
    logic        lerr_q, lerr_d;   // sticky lock error
    logic        sw_adv;           // software sync pulse
    logic        sclk_rise;        // serial clock rising
    logic        sclk_fall;        // serial clock falling
    logic        is_rd;            // transfer is a read
    logic [4:0]  addr;             // transfer address
    logic        lsb_first;        // bit order
    logic [5:0]  total;            // bits in data phase
    logic [39:0] rd_word;          // readback value
    logic [5:0]  rd_idx;           // readback bit index
    logic [39:0] sh_n;             // shift with new bit
    logic        last_bit;         // final data bit
    logic        lerr_clr;         // primary read done

    // decode of the current transfer
    assign sclk_rise = SCLK & ~sclk_q;
    assign sclk_fall = ~SCLK & sclk_q;
    assign lsb_first = pri_q[`SDC_P_LSB_FIRST];
    assign is_rd     = instr_q[`SDC_INSTR_RD];
    assign addr      = instr_q[`SDC_INSTR_ADDR_HI:0];
    assign total     = (addr == `SDC_ADDR_SEC) ? `SDC_SEC_BITS : `SDC_PRI_BITS;
    assign rd_word   = (addr == `SDC_ADDR_SEC) ? sec_q :
                       (addr == `SDC_ADDR_PRI) ? {8'h00, pri_q | ({31'h0, lerr_q} << `SDC_P_LOCK_ERR)} :
                       40'h00_0000_0000; // unmapped reads zero
    assign rd_idx    = lsb_first ? cnt_q : total - 6'd1 - cnt_q;
    assign sh_n      = lsb_first ? {SDIO_I, sh_q[39:1]} : {sh_q[38:0], SDIO_I};
    assign last_bit  = (st_q == SDC_DATA) && sclk_rise && (cnt_q == total - 6'd1);
    assign lerr_clr  = last_bit && is_rd && (addr == `SDC_ADDR_PRI);

    // serial port and register file, next values
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        instr_d = instr_q;
        sh_d    = sh_q;
        out_d   = out_q;
        pri_d   = pri_q;
        sec_d   = sec_q;
        sw_adv  = 1'b0;
        // set wins over readback clear
        lerr_d  = (lerr_q & ~lerr_clr)
                | ((pri_q[`SDC_P_AUTO_SYNC] | pri_q[`SDC_P_HW_SYNC]) & ~PLL_LOCKED);
        if (CS_N) begin
            st_d  = SDC_IDLE;
            cnt_d = 6'd0;
        end else begin
            case (st_q)
                SDC_IDLE: begin
                    st_d  = SDC_INSTR;
                    cnt_d = 6'd0;
                    if (sclk_rise) begin
                        instr_d = lsb_first ? {SDIO_I, 7'h00} : {7'h00, SDIO_I};
                        cnt_d   = 6'd1;
                    end
                end
                SDC_INSTR: begin
                    if (sclk_rise) begin
                        instr_d = lsb_first ? {SDIO_I, instr_q[7:1]} : {instr_q[6:0], SDIO_I};
                        cnt_d   = cnt_q + 6'd1;
                        if (cnt_q[2:0] == `SDC_INSTR_BITS) begin
                            st_d  = SDC_DATA;
                            cnt_d = 6'd0;
                        end
                    end
                end
                SDC_DATA: begin
                    if (sclk_fall && is_rd) begin
                        out_d = rd_word[rd_idx];
                    end
                    if (sclk_rise) begin
                        sh_d  = sh_n;
                        cnt_d = cnt_q + 6'd1;
                        if (last_bit) begin
                            st_d = SDC_WAIT;
                            // commit only a complete transfer
                            if (!is_rd && addr == `SDC_ADDR_SEC) begin
                                sec_d = sh_n & `SDC_S_WR_MASK;
                            end else if (!is_rd && addr == `SDC_ADDR_PRI) begin
                                pri_d  = (lsb_first ? sh_n[39:8] : sh_n[31:0]) & `SDC_P_WR_MASK;
                                sw_adv = lsb_first ? sh_n[8 + `SDC_P_SW_SYNC] : sh_n[`SDC_P_SW_SYNC];
                            end
                        end
                    end
                end
                SDC_WAIT: begin
                    st_d = SDC_WAIT;
                end
                default: begin
                    st_d = SDC_IDLE;
                end
            endcase
        end
    end

    // serial port and register file, registers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st_q    <= SDC_IDLE;
            cnt_q   <= 6'd0;
            instr_q <= 8'h00;
            sh_q    <= 40'h00_0000_0000;
            out_q   <= 1'b0;
            sclk_q  <= 1'b0;
            pri_q   <= `SDC_P_RESET;
            sec_q   <= `SDC_S_RESET;
            lerr_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            instr_q <= instr_d;
            sh_q    <= sh_d;
            out_q   <= out_d;
            sclk_q  <= SCLK;
            pri_q   <= pri_d;
            sec_q   <= sec_d;
            lerr_q  <= lerr_d;
        end
    end

    // readback pins follow wire mode
    assign SDIO_O  = out_q;
    assign SDO_O   = out_q;
    assign SDIO_OE = ~CS_N && (st_q == SDC_DATA) && is_rd && ~pri_q[`SDC_P_THREE_WIRE];
    assign SDO_OE  = ~CS_N && (st_q == SDC_DATA) && is_rd && pri_q[`SDC_P_THREE_WIRE];

    logic       run;       // digital logic running
    logic       auto_sync; // pin is sync reference
    logic       hw_sync;   // pin is advance input
    logic       ref_q;     // previous shared pin level
    logic       ref_rise;  // shared pin rising
    logic       sync_clk;  // internal sync clock

    assign run       = ~pri_q[`SDC_P_DIG_PD];
    assign auto_sync = pri_q[`SDC_P_AUTO_SYNC];
    assign hw_sync   = pri_q[`SDC_P_HW_SYNC];
    assign ref_rise  = LOCK_SYNC_I & ~ref_q;

    // sync clock divider with advance and alignment
    sdc_sync_div u_sync_div (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .run       (run),
        .advance   (sw_adv | (hw_sync & ref_rise)),
        .align     (auto_sync & ~hw_sync & ref_rise),
        .align_val (pri_q[`SDC_P_HS_SYNC] ? 2'd1 : 2'd0),
        .sync_clk  (sync_clk)
    );

    // shared pin: lock output only when not a sync input
    assign LOCK_SYNC_OE = sec_q[`SDC_S_LOCK_DET_EN] & ~auto_sync & ~hw_sync;
    assign LOCK_SYNC_O  = PLL_LOCKED;
    assign SYNC_OUT     = sync_clk;
    assign SYNC_OUT_OE  = ~pri_q[`SDC_P_SYNC_GATE];
    assign HS_SYNC_EN   = pri_q[`SDC_P_HS_SYNC];
    assign DIG_CLK_EN   = run;
    assign PFD_IN_EN    = ~pri_q[`SDC_P_PFD_IN_PD];

    // analog controls from secondary_control
    assign DAC_PD          = sec_q[`SDC_S_DAC_PD];
    assign DAC_OUT_OE      = ~sec_q[`SDC_S_DAC_PD];
    assign BANDGAP_PD      = sec_q[`SDC_S_BG_PD];
    assign DRV_INT_RSET    = sec_q[`SDC_S_INT_RSET];
    assign DRV_EXT_RSET_EN = ~sec_q[`SDC_S_INT_RSET];
    assign RISE_SURGE_EN   = sec_q[`SDC_S_RISE_HI:`SDC_S_RISE_LO];
    assign FALL_SURGE_EN   = sec_q[`SDC_S_FALL_HI:`SDC_S_FALL_LO];

    logic        hold_end_q, hold_end_d; // dwell at upper word
    logic        ret_q, ret_d;           // returned to start word
    logic        ps_q;                   // previous profile select
    logic        ps_rise;                // new sweep requested
    logic [19:0] bg_cnt_q, bg_cnt_d;     // band-gap settle counter
    logic        bg_ok_q, bg_ok_d;       // band-gap settled

    assign ps_rise = PROFILE_SELECT_BIT0 & ~ps_q;

    // sweep end behaviour and band-gap settling, next values
    always_comb begin
        hold_end_d = hold_end_q;
        ret_d      = ret_q;
        if (run) begin
            if (SWEEP_AT_END && !pri_q[`SDC_P_NO_DWELL]) begin
                hold_end_d = 1'b1;
                ret_d      = 1'b0;
            end else if (SWEEP_AT_END) begin
                ret_d      = 1'b1;
                hold_end_d = 1'b0;
            end else if (ps_rise) begin
                hold_end_d = 1'b0;
                ret_d      = 1'b0;
            end
        end
        bg_cnt_d = bg_cnt_q;
        bg_ok_d  = bg_ok_q;
        if (sec_q[`SDC_S_BG_PD]) begin
            bg_cnt_d = 20'd0;
            bg_ok_d  = 1'b0;
        end else if (!bg_ok_q) begin
            bg_cnt_d = bg_cnt_q + 20'd1;
            bg_ok_d  = (bg_cnt_q >= 20'(BG_SETTLE_CYC - 1));
        end
    end

    // sweep and band-gap registers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            hold_end_q <= 1'b0;
            ret_q      <= 1'b0;
            ps_q       <= 1'b0;
            ref_q      <= 1'b0;
            bg_cnt_q   <= 20'd0;
            bg_ok_q    <= 1'b0;
        end else begin
            hold_end_q <= hold_end_d;
            ret_q      <= ret_d;
            ps_q       <= run ? PROFILE_SELECT_BIT0 : ps_q;
            ref_q      <= LOCK_SYNC_I;
            bg_cnt_q   <= bg_cnt_d;
            bg_ok_q    <= bg_ok_d;
        end
    end

    assign SWEEP_HOLD_END     = hold_end_q;
    assign SWEEP_RETURN_START = ret_q;
    assign BANDGAP_SETTLED    = bg_ok_q;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    a_lock_err_set: assert property ((auto_sync || hw_sync) && !PLL_LOCKED |=> lerr_q)
        else $error("lock loss did not set the error flag");
    a_lock_err_sticky: assert property (lerr_q && !lerr_clr |=> lerr_q)
        else $error("lock error dropped without readback");
    a_lock_err_clear: assert property (lerr_clr && PLL_LOCKED |=> !lerr_q)
        else $error("primary readback did not clear lock error");
    a_shared_pin_dir: assert property (hw_sync || auto_sync |-> !LOCK_SYNC_OE)
        else $error("shared pin driven while a sync input");
    a_lock_det_out: assert property (sec_q[`SDC_S_LOCK_DET_EN] && !auto_sync && !hw_sync
                                     |-> LOCK_SYNC_OE && LOCK_SYNC_O == PLL_LOCKED)
        else $error("lock indication missing on shared pin");
    a_sync_gate: assert property (pri_q[`SDC_P_SYNC_GATE] |-> !SYNC_OUT_OE)
        else $error("sync pin driven while gated");
    a_three_wire: assert property (pri_q[`SDC_P_THREE_WIRE] |-> !SDIO_OE)
        else $error("data pin driven in three-wire mode");
    a_sweep_return: assert property (run && SWEEP_AT_END && pri_q[`SDC_P_NO_DWELL]
                                     |=> SWEEP_RETURN_START && !SWEEP_HOLD_END)
        else $error("no-dwell sweep did not return to start");
    a_sweep_dwell: assert property (run && SWEEP_AT_END && !pri_q[`SDC_P_NO_DWELL]
                                    |=> SWEEP_HOLD_END ##1 (SWEEP_HOLD_END || $past(ps_rise)))
        else $error("sweep did not dwell on upper word");
    a_dac_hiz: assert property (DAC_PD |-> !DAC_OUT_OE)
        else $error("converter output driven while powered down");
    a_bg_restart: assert property (BANDGAP_PD |=> !BANDGAP_SETTLED)
        else $error("band-gap settled while powered down");
    a_sw_sync_self: assert property (sw_adv |=> !pri_q[`SDC_P_SW_SYNC])
        else $error("software sync bit did not self-clear");

    c_pri_write: cover property (last_bit && !is_rd && addr == `SDC_ADDR_PRI);
    c_sec_write: cover property (last_bit && !is_rd && addr == `SDC_ADDR_SEC);
    c_pri_read:  cover property (lerr_clr && lerr_q);
    c_hw_adv:    cover property (hw_sync && ref_rise);
endmodule
`default_nettype wire

// >>> tb/sdc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host on the serial control port, bit-banged off the system clock
module sdc_host (
    input  wire logic clk,    // system clock
    input  wire logic sdio_w, // resolved data pin level
    input  wire logic sdo_w,  // resolved serial output pin level
    output logic      sclk,   // serial clock
    output logic      cs_n,   // select, low
    output logic      sdio_d  // level put on the data pin
);
    logic lsb_first  = 1'b0; // order the device expects now
    logic three_wire = 1'b0; // readback on the separate pin
    initial begin
        sclk   = 1'b0;
        cs_n   = 1'b1;
        sdio_d = 1'b0;
    end
    // one transfer: instruction byte, then nbits data bits
    task automatic xfer(input logic rd, input logic [4:0] addr, input int nbits,
                        input logic [39:0] wd, output logic [39:0] rdat);
        logic [7:0] ins;
        int         k;
        ins  = {rd, 2'b00, addr};
        rdat = '0;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 0; i < 8 + nbits; i++) begin
            k    = (i < 8) ? (lsb_first ? i : 7 - i) : (lsb_first ? i - 8 : nbits + 7 - i);
            sclk = 1'b0;
            // released pin shows a changing pattern, never the last bit
            sdio_d = (rd && i >= 8) ? ~sdio_d : ((i < 8) ? ins[k] : wd[k]);
            repeat (3) @(negedge clk);
            if (rd && i >= 8) begin
                rdat[k] = three_wire ? sdo_w : sdio_w;
            end
            sclk = 1'b1;
            repeat (2) @(negedge clk);
        end
        sclk = 1'b0;
        @(negedge clk);
        cs_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// >>> tb/sdc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"
// self-checking bench for the control-configuration bank
module sdc_top_tb;
    logic clk_sys = 1'b0, rst_n = 1'b0, lock_sync_i = 1'b0, pll_locked = 1'b1; // driven inputs
    logic sweep_at_end = 1'b0, profile_sel = 1'b1, bad_oe = 1'b0;               // sweep inputs, oe flag
    wire logic sclk, cs_n, sdio_d, sdio_o, sdio_oe, sdo_o, sdo_oe, lk_o, lk_oe;  // serial and shared pin
    wire logic sync_out, sync_oe, hold_end, ret_start, dig_en, pfd_en, hs_en;    // sync and sweep
    wire logic dac_pd, dac_oe, bg_pd, bg_ok, int_rset, ext_rset;                 // analog controls
    wire logic [2:0] rise_en, fall_en;                                           // surge legs
    wire logic sdio_w = sdio_oe ? sdio_o : sdio_d;                               // data pin level
    wire logic sdo_w  = sdo_oe ? sdo_o : ~sdo_o;                                 // floating output pin
    int fails = 0, comparisons = 0, cyc = 0, last_rise = 0, p0;                  // counters
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    always @(posedge sync_out) last_rise = cyc;
    always @(posedge clk_sys) if (host.three_wire && sdio_oe) bad_oe <= 1'b1;
    sdc_top #(.BG_SETTLE_CYC(20)) dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .SDIO_I(sdio_w),
        .SDIO_O(sdio_o), .SDIO_OE(sdio_oe), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .LOCK_SYNC_I(lock_sync_i),
        .LOCK_SYNC_O(lk_o), .LOCK_SYNC_OE(lk_oe), .PLL_LOCKED(pll_locked), .SYNC_OUT(sync_out),
        .SYNC_OUT_OE(sync_oe), .SWEEP_AT_END(sweep_at_end), .PROFILE_SELECT_BIT0(profile_sel),
        .SWEEP_HOLD_END(hold_end), .SWEEP_RETURN_START(ret_start), .DIG_CLK_EN(dig_en), .PFD_IN_EN(pfd_en),
        .HS_SYNC_EN(hs_en), .DAC_PD(dac_pd), .DAC_OUT_OE(dac_oe), .BANDGAP_PD(bg_pd),
        .BANDGAP_SETTLED(bg_ok), .DRV_INT_RSET(int_rset), .DRV_EXT_RSET_EN(ext_rset),
        .RISE_SURGE_EN(rise_en), .FALL_SURGE_EN(fall_en));
    sdc_host host (.clk(clk_sys), .sdio_w(sdio_w), .sdo_w(sdo_w), .sclk(sclk), .cs_n(cs_n), .sdio_d(sdio_d));
    // counted comparison, reports at once
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input int n, input logic [39:0] d);
        logic [39:0] x;
        host.xfer(1'b0, a, n, d, x);
    endtask
    task automatic rdc(input string nm, input logic [4:0] a, input int n, input logic [39:0] e);
        logic [39:0] x;
        host.xfer(1'b1, a, n, '0, x);
        chk(nm, e, x);
    endtask
    // rising edge on the shared pin, two cycles wide
    task automatic pin_pulse();
        lock_sync_i = 1'b1;
        repeat (2) @(negedge clk_sys);
        lock_sync_i = 1'b0;
    endtask
    task automatic sweep_pulse();
        sweep_at_end = 1'b1;
        @(negedge clk_sys);
        sweep_at_end = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    // sync clock rises drift by the expected count modulo four
    task automatic phase_chk(input string nm, input int exp);
        repeat (12) @(negedge clk_sys);
        chk(nm, exp, (last_rise - p0) % 4);
    endtask
    task automatic test_done();
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #1_000_000;
        fails++;
        test_done();
    end
    initial begin
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        chk("rst oe", 5'h1_F, {sync_oe, dac_oe, dig_en, pfd_en, ext_rset});
        chk("rst lk_oe", 1'b0, lk_oe);
        rdc("rst pri", `SDC_ADDR_PRI, 32, `SDC_P_RESET);
        rdc("rst sec", `SDC_ADDR_SEC, 40, `SDC_S_RESET);
        rdc("unmapped", 5'h05, 32, 40'h00_0000_0000);
        sweep_pulse();
        chk("hold", 2'b10, {hold_end, ret_start});
        profile_sel = 1'b0;
        repeat (2) @(negedge clk_sys);
        profile_sel = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("hold clr", 2'b00, {hold_end, ret_start});
        wr(`SDC_ADDR_PRI, 32, 40'h00_0001_0000);
        sweep_pulse();
        chk("ret", 2'b01, {hold_end, ret_start});
        profile_sel = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("ret low", 1'b1, ret_start);
        profile_sel = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("ret clr", 1'b0, ret_start);
        wr(`SDC_ADDR_PRI, 32, 40'h00_0001_00D1);
        sweep_pulse();
        chk("pd frozen", 1'b0, ret_start);
        chk("pd pins", 4'b0001, {dig_en, pfd_en, sync_oe, hs_en});
        rdc("pd read", `SDC_ADDR_PRI, 32, 40'h00_0001_00D1);
        wr(`SDC_ADDR_PRI, 32, 40'h00_0000_8000);
        host.lsb_first = 1'b1;
        rdc("lsb", `SDC_ADDR_PRI, 32, 40'h00_0000_8000);
        wr(`SDC_ADDR_PRI, 32, 40'h00_0000_C000);
        host.three_wire = 1'b1;
        rdc("3wire", `SDC_ADDR_PRI, 32, 40'h00_0000_C000);
        chk("sdio oe", 1'b0, bad_oe);
        wr(`SDC_ADDR_PRI, 32, 40'h00_0000_0000);
        host.lsb_first = 1'b0;
        host.three_wire = 1'b0;
        rdc("msb", `SDC_ADDR_PRI, 32, 40'h00_0000_0000);
        wr(`SDC_ADDR_SEC, 40, 40'h82_AA74_0000);
        chk("sec b", 12'b1_0_1_0_0_1_101_010,
            {dac_pd, dac_oe, bg_pd, bg_ok, int_rset, ext_rset, rise_en, fall_en});
        rdc("sec rd", `SDC_ADDR_SEC, 40, 40'h82_AA74_0000);
        // a cut transfer must leave the register as it was
        wr(`SDC_ADDR_SEC, 16, 40'h00_0000_FFFF);
        rdc("sec cut", `SDC_ADDR_SEC, 40, 40'h82_AA74_0000);
        pll_locked = 1'b0;
        @(negedge clk_sys);
        chk("lk pin", 2'b10, {lk_oe, lk_o});
        pll_locked = 1'b1;
        // reference back on: not settled at once, settled later
        wr(`SDC_ADDR_SEC, 40, 40'h01_5574_0000);
        chk("bg waking", 2'b00, {bg_pd, bg_ok});
        repeat (25) @(negedge clk_sys);
        chk("bg settled", 2'b01, {bg_pd, bg_ok});
        chk("sec a", 9'b0_1_0_010_101, {dac_pd, int_rset, ext_rset, rise_en, fall_en});
        chk("lk off", 1'b0, lk_oe);
        p0 = last_rise;
        wr(`SDC_ADDR_PRI, 32, 40'h00_0000_0004);
        phase_chk("sw sync", 3);
        rdc("sw clr", `SDC_ADDR_PRI, 32, 40'h00_0000_0000);
        wr(`SDC_ADDR_PRI, 32, 40'h00_0000_0002);
        chk("hw oe", 1'b0, lk_oe);
        p0 = last_rise;
        pin_pulse();
        phase_chk("hw sync", 3);
        pll_locked = 1'b0;
        repeat (2) @(negedge clk_sys);
        pll_locked = 1'b1;
        rdc("lock err", `SDC_ADDR_PRI, 32, 40'h00_0100_0002);
        rdc("err clr", `SDC_ADDR_PRI, 32, 40'h00_0000_0002);
        wr(`SDC_ADDR_PRI, 32, 40'h00_0000_0008);
        chk("auto oe", 1'b0, lk_oe);
        pin_pulse();
        repeat (11) @(negedge clk_sys);
        p0 = last_rise;
        pin_pulse();
        phase_chk("auto sync", 1);
        test_done();
    end
endmodule
`default_nettype wire
